// file: hdl/floppy_status_cfg.svh
`ifndef FLOPPY_STATUS_CFG_SVH
`define FLOPPY_STATUS_CFG_SVH

// register indexes; byte address is four times the index
`define IDX_W            4
`define IDX_SENSE_RATE   4'h7
`define IDX_DRIVE_THIRD  4'h8
`define IDX_BLOCK_STAT   4'h9

// avalon answers
`define RESP_OK          2'h0
`define RESP_SLVERR      2'h2

// rate control fields
`define RATE_LO_BIT      0
`define RATE_HI_BIT      1
`define PRECOMP_BIT      2
`define RATE_RST         2'h2
`define PRECOMP_RST      1'h0
`define RATE_HI_RST      1'h1
`define RATE_LO_RST      1'h0

// rate codes that mean low density media
`define RATE_300K        2'h1
`define RATE_250K        2'h2

// sense readback fields
`define MEDIA_BIT        7
`define XFER_GATE_BIT    3
`define EXT_ONES         4'hF
`define ALT_ZEROS        3'h0
`define LEGACY_EN        8'h80
`define ALL_EN           8'hFF

`endif

// file: hdl/floppy_status_pkg.sv
package floppy_status_pkg;

    // compatibility mode chosen by the controller configuration
    typedef enum logic [1:0] {
        MODE_LEGACY,
        MODE_EXTENDED,
        MODE_ALT
    } compat_mode_e;

    typedef logic [1:0] rate_code_t;

endpackage

// file: hdl/floppy_status_readback_regs.sv
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`include "floppy_status_cfg.svh"

module floppy_status_readback_regs
    import floppy_status_pkg::*;
#(
    parameter int DATA_W = 32                    // avalon data width
)
(
    input  wire logic                core_clk_i,          // 25 MHz clock
    input  wire logic                rst_i,               // sync reset, high
    input  wire logic [`IDX_W-1:0]   avs_address_i,       // word index
    input  wire logic                avs_read_i,          // read request
    input  wire logic                avs_write_i,         // write request
    input  wire logic [DATA_W-1:0]   avs_writedata_i,     // write data
    input  wire logic [DATA_W/8-1:0] avs_byteenable_i,    // byte lanes
    output logic      [DATA_W-1:0]   avs_readdata_o,      // read data
    output logic                     avs_waitrequest_o,   // stall
    output logic      [1:0]          avs_response_o,      // ok or slave error
    input  wire compat_mode_e        mode_i,              // compatibility mode
    input  wire logic                media_change_n_i,    // media change, low
    input  wire logic                xfer_req_gate_i,     // output ctl bit 3
    input  wire logic                fault_flag_i,        // drive fault
    input  wire logic                write_protect_i,     // write protected
    input  wire logic                drive_ready_i,       // drive ready
    input  wire logic                at_track_zero_i,     // head at track 0
    input  wire logic                two_sided_i,         // two-sided media
    input  wire logic                head_sel_i,          // head address
    input  wire logic                unit_sel_hi_i,       // unit select 1
    input  wire logic                unit_sel_lo_i,       // unit select 0
    output logic                     rate_sel_hi_o,       // rate code bit 1
    output logic                     rate_sel_lo_o,       // rate code bit 0
    output logic                     precomp_off_o,       // precomp disabled
    output logic      [7:0]          sense_drive_en_o     // lanes driven on read
);

    // state
    rate_code_t  rate_code;
    logic        precomp_off;

    // bus decode
    logic        req_new;
    logic        req_done;
    logic        hit_sense_rate;
    logic        hit_drive_third;
    logic        hit_block_stat;
    logic        hit_any;
    logic        wr_rate;
    logic        wr_alt;

    // a request is seen while stalled, and finishes one cycle later
    assign req_new  = (avs_read_i || avs_write_i) && avs_waitrequest_o;
    assign req_done = (avs_read_i || avs_write_i) && !avs_waitrequest_o;

    assign hit_sense_rate  = (avs_address_i == `IDX_SENSE_RATE);
    assign hit_drive_third = (avs_address_i == `IDX_DRIVE_THIRD);
    assign hit_block_stat  = (avs_address_i == `IDX_BLOCK_STAT);
    assign hit_any         = hit_sense_rate || hit_drive_third || hit_block_stat;

    // only low lane carries the register; index 7 write reaches rate control
    assign wr_rate = req_done && avs_write_i && hit_sense_rate
                     && avs_byteenable_i[0];
    assign wr_alt  = wr_rate && (mode_i == MODE_ALT);

    // read values
    logic [7:0]  sense_byte;
    logic [7:0]  sense_en;
    logic [7:0]  drive_third;
    logic [7:0]  block_stat;
    logic [7:0]  read_byte;
    logic [7:0]  read_en;

    sense_readback_mux u_sense (
        .mode_i           (mode_i),
        .media_change_n_i (media_change_n_i),
        .xfer_req_gate_i  (xfer_req_gate_i),
        .precomp_off_i    (precomp_off),
        .rate_code_i      (rate_code),
        .sense_byte_o     (sense_byte),
        .sense_en_o       (sense_en)
    );

    assign drive_third = {fault_flag_i, write_protect_i, drive_ready_i,
                        at_track_zero_i, two_sided_i, head_sel_i,
                        unit_sel_hi_i, unit_sel_lo_i};

    // block view: mode, precomp and rate as they stand now
    assign block_stat = {3'h0, mode_i, precomp_off, rate_code};

    assign read_byte = hit_sense_rate  ? sense_byte  :
                       hit_drive_third ? drive_third :
                       hit_block_stat  ? block_stat  : 8'h00;

    assign read_en = hit_sense_rate ? sense_en : `ALL_EN;

    // write values
    rate_code_t  next_rate_code;
    logic        next_precomp_off;

    // upper bits are ignored; software is expected to write zero there
    assign next_rate_code = wr_rate ?
        {avs_writedata_i[`RATE_HI_BIT], avs_writedata_i[`RATE_LO_BIT]} :
        rate_code;

    // precompensation bit is written only in alternate mode
    assign next_precomp_off = wr_alt ?
        avs_writedata_i[`PRECOMP_BIT] : precomp_off;

    // registers
    // reads never touch rate or precomp state
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rate_code   <= `RATE_RST;
            precomp_off <= `PRECOMP_RST;
        end else begin
            rate_code   <= next_rate_code;
            precomp_off <= next_precomp_off;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rate_sel_hi_o <= `RATE_HI_RST;
            rate_sel_lo_o <= `RATE_LO_RST;
            precomp_off_o <= `PRECOMP_RST;
        end else begin
            rate_sel_hi_o <= next_rate_code[`RATE_HI_BIT];
            rate_sel_lo_o <= next_rate_code[`RATE_LO_BIT];
            precomp_off_o <= next_precomp_off;
        end
    end

    // avalon handshake: one wait state on every access
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !req_new;
        end
    end

    // read data is captured when the stall drops and stands one cycle
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            avs_readdata_o   <= '0;
            avs_response_o   <= `RESP_OK;
            sense_drive_en_o <= 8'h00;
        end else if (req_new) begin
            avs_readdata_o   <= avs_read_i ?
                                {{(DATA_W-8){1'b0}}, read_byte} : '0;
            avs_response_o   <= hit_any ? `RESP_OK : `RESP_SLVERR;
            sense_drive_en_o <= avs_read_i ? read_en : 8'h00;
        end else begin
            avs_readdata_o   <= '0;
            avs_response_o   <= `RESP_OK;
            sense_drive_en_o <= 8'h00;
        end
    end

    // checks
    logic rd_sense;
    logic rd_third;
    logic wr_idx7;

    assign rd_sense = avs_read_i && avs_waitrequest_o && hit_sense_rate;
    assign rd_third = avs_read_i && avs_waitrequest_o && hit_drive_third;
    assign wr_idx7  = avs_write_i && !avs_waitrequest_o && hit_sense_rate
                      && avs_byteenable_i[0];

    property p_answer_one;
        @(posedge core_clk_i) disable iff (rst_i)
        (avs_read_i || avs_write_i) && avs_waitrequest_o
            |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
    endproperty
    a_answer_one: assert property (p_answer_one)
        else $error("access not answered after one wait state");

    property p_third;
        @(posedge core_clk_i) disable iff (rst_i)
        rd_third |=> avs_readdata_o[7:0] == {$past(fault_flag_i),
            $past(write_protect_i), $past(drive_ready_i),
            $past(at_track_zero_i), $past(two_sided_i), $past(head_sel_i),
            $past(unit_sel_hi_i), $past(unit_sel_lo_i)};
    endproperty
    a_third: assert property (p_third)
        else $error("drive status byte three order wrong");

    property p_legacy;
        @(posedge core_clk_i) disable iff (rst_i)
        rd_sense && mode_i == MODE_LEGACY
            |=> avs_readdata_o[7] == !$past(media_change_n_i)
                && avs_readdata_o[6:0] == 7'h00
                && sense_drive_en_o == 8'h80;
    endproperty
    a_legacy: assert property (p_legacy)
        else $error("legacy sense readback wrong");

    property p_legacy_float;
        @(posedge core_clk_i) disable iff (rst_i)
        rd_sense && mode_i == MODE_LEGACY |=> sense_drive_en_o[6:0] == 7'h00;
    endproperty
    a_legacy_float: assert property (p_legacy_float)
        else $error("legacy low bits driven");

    property p_ext_high;
        @(posedge core_clk_i) disable iff (rst_i)
        rd_sense && mode_i == MODE_EXTENDED
            |=> avs_readdata_o[7:3] == {!$past(media_change_n_i), 4'hF};
    endproperty
    a_ext_high: assert property (p_ext_high)
        else $error("extended upper sense bits wrong");

    property p_ext_rate;
        @(posedge core_clk_i) disable iff (rst_i)
        rd_sense && mode_i == MODE_EXTENDED
            |=> avs_readdata_o[2:1] == {rate_sel_hi_o, rate_sel_lo_o};
    endproperty
    a_ext_rate: assert property (p_ext_rate)
        else $error("extended rate bits wrong");

    property p_ext_density;
        @(posedge core_clk_i) disable iff (rst_i)
        rd_sense && mode_i == MODE_EXTENDED
            |=> avs_readdata_o[0] == (rate_sel_hi_o ^ rate_sel_lo_o);
    endproperty
    a_ext_density: assert property (p_ext_density)
        else $error("density bit wrong");

    property p_alt_media;
        @(posedge core_clk_i) disable iff (rst_i)
        rd_sense && mode_i == MODE_ALT
            |=> avs_readdata_o[7] == $past(media_change_n_i);
    endproperty
    a_alt_media: assert property (p_alt_media)
        else $error("alternate media bit inverted");

    property p_alt_low;
        @(posedge core_clk_i) disable iff (rst_i)
        rd_sense && mode_i == MODE_ALT
            |=> avs_readdata_o[6:0] == {3'h0, $past(xfer_req_gate_i),
                precomp_off_o, rate_sel_hi_o, rate_sel_lo_o};
    endproperty
    a_alt_low: assert property (p_alt_low)
        else $error("alternate low sense bits wrong");

    property p_rate_write;
        @(posedge core_clk_i) disable iff (rst_i)
        wr_idx7 |=> {rate_sel_hi_o, rate_sel_lo_o} == $past(avs_writedata_i[1:0]);
    endproperty
    a_rate_write: assert property (p_rate_write)
        else $error("rate control write lost");

    property p_rate_reset;
        @(posedge core_clk_i)
        rst_i ##1 !rst_i |-> {rate_sel_hi_o, rate_sel_lo_o} == 2'h2
            && !precomp_off_o;
    endproperty
    a_rate_reset: assert property (p_rate_reset)
        else $error("rate code reset value wrong");

    property p_precomp;
        @(posedge core_clk_i) disable iff (rst_i)
        wr_idx7 && mode_i == MODE_ALT
            |=> precomp_off_o == $past(avs_writedata_i[2]);
    endproperty
    a_precomp: assert property (p_precomp)
        else $error("precomp bit not written in alternate mode");

    property p_precomp_hold;
        @(posedge core_clk_i) disable iff (rst_i)
        wr_idx7 && mode_i != MODE_ALT |=> $stable(precomp_off_o);
    endproperty
    a_precomp_hold: assert property (p_precomp_hold)
        else $error("precomp changed outside alternate mode");

    property p_no_side;
        @(posedge core_clk_i) disable iff (rst_i)
        !wr_idx7 |=> $stable({rate_sel_hi_o, rate_sel_lo_o, precomp_off_o});
    endproperty
    a_no_side: assert property (p_no_side)
        else $error("rate state changed without a write");

    property p_third_en;
        @(posedge core_clk_i) disable iff (rst_i)
        rd_third |=> sense_drive_en_o == 8'hFF;
    endproperty
    a_third_en: assert property (p_third_en)
        else $error("drive status byte three not fully driven");

    property p_unmapped;
        @(posedge core_clk_i) disable iff (rst_i)
        (avs_read_i || avs_write_i) && avs_waitrequest_o && !hit_any
            |=> avs_response_o == 2'h2 && avs_readdata_o == '0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");

    // a stalled or idle bus must never show driven lanes
    property p_idle_quiet;
        @(posedge core_clk_i) disable iff (rst_i)
        avs_waitrequest_o |-> avs_readdata_o == '0 && sense_drive_en_o == 8'h00;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("read lanes driven outside an answer");

    property p_ext_en;
        @(posedge core_clk_i) disable iff (rst_i)
        rd_sense && mode_i == MODE_EXTENDED |=> sense_drive_en_o == 8'hFF;
    endproperty
    a_ext_en: assert property (p_ext_en)
        else $error("extended sense byte not fully driven");

    property p_alt_en;
        @(posedge core_clk_i) disable iff (rst_i)
        rd_sense && mode_i == MODE_ALT |=> sense_drive_en_o == 8'hFF;
    endproperty
    a_alt_en: assert property (p_alt_en)
        else $error("alternate sense byte not fully driven");

    property p_alt_gate;
        @(posedge core_clk_i) disable iff (rst_i)
        rd_sense && mode_i == MODE_ALT
            |=> avs_readdata_o[3] == $past(xfer_req_gate_i);
    endproperty
    a_alt_gate: assert property (p_alt_gate)
        else $error("alternate gating bit not mirrored");

    property p_alt_rate;
        @(posedge core_clk_i) disable iff (rst_i)
        rd_sense && mode_i == MODE_ALT
            |=> avs_readdata_o[2:0] == {precomp_off_o, rate_sel_hi_o, rate_sel_lo_o};
    endproperty
    a_alt_rate: assert property (p_alt_rate)
        else $error("alternate precomp or rate bits wrong");

endmodule

// file: hdl/sense_readback_mux.sv
`timescale 1ns/1ps
`include "floppy_status_cfg.svh"

module sense_readback_mux
    import floppy_status_pkg::*;
(
    input  wire compat_mode_e mode_i,           // active compatibility mode
    input  wire logic         media_change_n_i, // media change, active low
    input  wire logic         xfer_req_gate_i,  // transfer request gating bit
    input  wire logic         precomp_off_i,    // precompensation disabled
    input  wire rate_code_t   rate_code_i,      // selected data-rate code
    output logic [7:0]        sense_byte_o,     // readback value, undriven bits 0
    output logic [7:0]        sense_en_o        // per bit, high where driven
);
    logic [7:0] raw_legacy;
    logic [7:0] raw_ext;
    logic [7:0] raw_alt;
    logic [7:0] raw_sel;
    logic       hi_density_n;

    // low density rates report one
    assign hi_density_n = (rate_code_i == `RATE_300K) || (rate_code_i == `RATE_250K);

    assign raw_legacy = {~media_change_n_i, 7'h00};
    assign raw_ext    = {~media_change_n_i, `EXT_ONES, rate_code_i, hi_density_n};
    assign raw_alt    = {media_change_n_i, `ALT_ZEROS, xfer_req_gate_i,
                         precomp_off_i, rate_code_i};

    assign raw_sel = (mode_i == MODE_EXTENDED) ? raw_ext :
                     (mode_i == MODE_ALT)      ? raw_alt : raw_legacy;

    // legacy leaves the low bits to the disk controller sharing the address
    assign sense_en_o = (mode_i == MODE_EXTENDED || mode_i == MODE_ALT) ?
                        `ALL_EN : `LEGACY_EN;

    genvar b;
    generate
        for (b = 0; b < 8; b = b + 1) begin : g_mask
            assign sense_byte_o[b] = raw_sel[b] & sense_en_o[b];
        end
    endgenerate

endmodule

// file: sim/test_floppy_status_readback_regs.sv
`timescale 1ns/1ps
`include "floppy_status_cfg.svh"

module test_floppy_status_readback_regs
    import floppy_status_pkg::*;
;
    logic         clk     = 1'b0;
    logic         rst     = 1'b1;
    logic [3:0]   addr    = 4'h0;
    logic         rd      = 1'b0;
    logic         wr      = 1'b0;
    logic [31:0]  wdata   = 32'h0;
    logic [3:0]   ben     = 4'hF;
    logic [31:0]  rdata;
    logic         waitreq;
    logic [1:0]   resp;
    compat_mode_e mode    = MODE_LEGACY;
    logic         mc_n    = 1'b1;
    logic         gate    = 1'b0;
    logic [7:0]   ds      = 8'h00;
    logic         r_hi;
    logic         r_lo;
    logic         pre;
    logic [7:0]   drv_en;
    logic [1:0]   exp_rate = 2'h2;
    logic         exp_pre  = 1'b0;
    int           err_count = 0;
    int           compares  = 0;

    floppy_status_readback_regs dut_u (
        .core_clk_i        (clk),
        .rst_i             (rst),
        .avs_address_i     (addr),
        .avs_read_i        (rd),
        .avs_write_i       (wr),
        .avs_writedata_i   (wdata),
        .avs_byteenable_i  (ben),
        .avs_readdata_o    (rdata),
        .avs_waitrequest_o (waitreq),
        .avs_response_o    (resp),
        .mode_i            (mode),
        .media_change_n_i  (mc_n),
        .xfer_req_gate_i   (gate),
        .fault_flag_i      (ds[7]),
        .write_protect_i   (ds[6]),
        .drive_ready_i     (ds[5]),
        .at_track_zero_i   (ds[4]),
        .two_sided_i       (ds[3]),
        .head_sel_i        (ds[2]),
        .unit_sel_hi_i     (ds[1]),
        .unit_sel_lo_i     (ds[0]),
        .rate_sel_hi_o     (r_hi),
        .rate_sel_lo_o     (r_lo),
        .precomp_off_o     (pre),
        .sense_drive_en_o  (drv_en)
    );

    always #20 clk = ~clk;

    task automatic wrap_up;
        $display("errors=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is sampled low; data taken at that edge
    // no cycle count assumed; a hang is left to the watchdog
    task automatic bus_wait;
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
    endtask

    task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp_d,
                          input logic [1:0] exp_r, input logic [7:0] exp_en);
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  e;
        @(posedge clk);
        rd   <= 1'b1;
        addr <= idx;
        bus_wait();
        d = rdata;
        r = resp;
        e = drv_en;
        rd <= 1'b0;
        chk_data(d, exp_d);
        chk_resp(r, exp_r);
        // lane enables only carry meaning for the shared sense address
        if (idx == `IDX_SENSE_RATE) begin
            chk_data({24'h0, e}, {24'h0, exp_en});
        end
    endtask

    task automatic av_write(input logic [3:0] idx, input logic [2:0] v, input logic [3:0] be);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= idx;
        wdata <= {29'h0, v};
        ben   <= be;
        bus_wait();
        wr  <= 1'b0;
        ben <= 4'hF;
    endtask

    task automatic chk_rate;
        @(posedge clk);
        chk_data({29'h0, pre, r_hi, r_lo}, {29'h0, exp_pre, exp_rate});
    endtask

    task automatic set_in(input compat_mode_e m, input logic mc, input logic g);
        @(posedge clk);
        mode <= m;
        mc_n <= mc;
        gate <= g;
    endtask

    task automatic test_reset_and_status;
        chk_rate();
        rd_chk(`IDX_BLOCK_STAT, 32'h02, `RESP_OK, 8'hFF);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            ds <= (i == 0) ? 8'hA5 : 8'h5A;
            rd_chk(`IDX_DRIVE_THIRD, (i == 0) ? 32'hA5 : 32'h5A, `RESP_OK, 8'hFF);
        end
    endtask

    task automatic test_legacy;
        for (int i = 0; i < 2; i++) begin
            set_in(MODE_LEGACY, i[0], 1'b1);
            rd_chk(`IDX_SENSE_RATE, {24'h0, ~i[0], 7'h0}, `RESP_OK, `LEGACY_EN);
        end
    endtask

    task automatic test_extended;
        logic [1:0] r;
        for (int i = 0; i < 4; i++) begin
            r = i[1:0];
            set_in(MODE_EXTENDED, i[0], 1'b0);
            av_write(`IDX_SENSE_RATE, {1'b0, r}, 4'h1);
            exp_rate = r;
            chk_rate();
            rd_chk(`IDX_SENSE_RATE, {24'h0, ~i[0], 4'hF, r, (r == 2'h1 || r == 2'h2)},
                   `RESP_OK, `ALL_EN);
        end
    endtask

    task automatic test_alt;
        av_write(`IDX_SENSE_RATE, 3'h5, 4'h1);
        set_in(MODE_ALT, 1'b0, 1'b0);
        av_write(`IDX_SENSE_RATE, 3'h5, 4'h1);
        exp_pre  = 1'b1;
        exp_rate = 2'h1;
        chk_rate();
        for (int i = 0; i < 4; i++) begin
            set_in(MODE_ALT, i[0], i[1]);
            rd_chk(`IDX_SENSE_RATE, {24'h0, i[0], 3'h0, i[1], 1'b1, 2'h1},
                   `RESP_OK, `ALL_EN);
        end
        av_write(`IDX_SENSE_RATE, 3'h2, 4'h1);
        exp_pre  = 1'b0;
        exp_rate = 2'h2;
        rd_chk(`IDX_SENSE_RATE, {24'h0, 1'b1, 3'h0, 1'b1, 1'b0, 2'h2}, `RESP_OK, `ALL_EN);
        av_write(`IDX_SENSE_RATE, 3'h6, 4'h1);
        exp_pre = 1'b1;
        chk_rate();
    endtask

    task automatic test_refusals;
        set_in(MODE_LEGACY, 1'b1, 1'b0);
        // precomp bit only writable in the alternate mode
        av_write(`IDX_SENSE_RATE, 3'h3, 4'h1);
        exp_rate = 2'h3;
        chk_rate();
        av_write(`IDX_SENSE_RATE, 3'h0, 4'hE);
        av_write(4'h3, 3'h1, 4'hF);
        av_write(`IDX_DRIVE_THIRD, 3'h1, 4'hF);
        chk_rate();
        rd_chk(4'h3, 32'h0, `RESP_SLVERR, 8'h00);
        rd_chk(`IDX_SENSE_RATE, 32'h0, `RESP_OK, `LEGACY_EN);
        rd_chk(`IDX_SENSE_RATE, 32'h0, `RESP_OK, `LEGACY_EN);
        rd_chk(`IDX_BLOCK_STAT, 32'h07, `RESP_OK, 8'hFF);
        chk_rate();
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        test_reset_and_status();
        test_legacy();
        test_extended();
        test_alt();
        test_refusals();
        repeat (2) @(posedge clk);
        wrap_up();
    end

    // whole sequence needs under two hundred cycles
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        wrap_up();
    end

endmodule
